// >>> bench/sdsc_host.sv
// Parameter unit model issuing setting writes
module sdsc_host (
	input  wire logic   i_clk,  // System clock
	input  wire logic   i_rej,  // Write refused
	output logic [4:0]  o_wr,   // Strobes scale,pole,reff,res,mpole
	output logic [15:0] o_wdata // Write data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_wr = 5'h00;
		o_wdata = 16'h0000;
	end
	// Data is inverted when idle so a stale word never looks valid
	task automatic wr(input int k, input logic [15:0] d, output logic rej);
		@(posedge i_clk);
		o_wr <= 5'h01 << k;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 5'h00;
		o_wdata <= ~d;
		#1 rej = i_rej;
	endtask : wr
endmodule : sdsc_host

// >>> bench/sdsc_sva.sv
// Port assertions for the speed display scaling block
module sdsc_sva (
	input wire logic                 I_CLK,       // Clock
	input wire logic                 I_NRST,      // Reset, low
	input wire logic                 I_WR_SCALE,  // Scale write
	input wire logic                 I_WR_MPOLE,  // Motor pole write
	input wire logic [15:0]          I_WDATA,     // Write data
	input wire logic [15:0]          I_OUT_FREQ,  // Output freq
	input wire sdsc_pkg::sdsc_ctrl_t I_CTRL_MODE, // Control mode
	input wire logic                 I_NET_OPT,   // Network card
	input wire logic [13:0]          O_SCALE,     // Scale
	input wire logic [7:0]           O_POLE,      // Pole setting
	input wire logic [6:0]           O_REFF,      // Reference freq
	input wire logic [3:0]           O_RES,       // Resolution
	input wire logic                 O_WR_REJ,    // Refused
	input wire logic [15:0]          O_SPD_MON,   // Speed monitor
	input wire sdsc_pkg::sdsc_unit_t O_OUT_UNIT,  // Output unit
	input wire sdsc_pkg::sdsc_unit_t O_SPD_UNIT,  // Speed unit
	input wire logic [2:0]           O_DASH,      // Dash flags
	input wire logic                 O_SPD_TENTH, // Tenth steps
	input wire logic                 O_TRQ_FINE   // Fine torque
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	scale_cap_a: assert property (O_SCALE <= 14'h270e)
		else $error("Scale above cap");
	scale_rej_a: assert property (
		I_WR_SCALE && I_WDATA > 16'h270e |=> O_WR_REJ && $stable(O_SCALE))
		else $error("Oversized scale taken");
	pole_legal_a: assert property (!O_POLE[0] &&
		(O_POLE < 8'h0b || (O_POLE > 8'h65 && O_POLE < 8'h6f)))
		else $error("Illegal pole setting");
	reff_legal_a: assert property (O_REFF inside {[7'h01:7'h78]})
		else $error("Reference out of range");
	mpole_fold_a: assert property (
		I_WR_MPOLE && I_WDATA == 16'h000c && O_POLE != 8'h00
		&& O_POLE < 8'h64 |=> O_POLE == 8'h02) else $error("Pole fold");
	tenth_sel_a: assert property (
		O_SPD_TENTH == (O_RES == 4'h1 || O_RES == 4'hb))
		else $error("Speed step select");
	trq_fine_a: assert property (O_TRQ_FINE == (O_RES > 4'h1))
		else $error("Torque step select");
	spd_rpm_a: assert property (O_SCALE == 14'h0000 &&
		O_POLE == 8'h00 && O_RES == 4'h0 && !I_NET_OPT &&
		I_CTRL_MODE == sdsc_pkg::SDSC_CM_VF |=>
		O_SPD_MON == 16'(32'($past(I_OUT_FREQ)) * 120 / 400))
		else $error("Speed conversion");
	spd_dash_a: assert property (O_DASH[2] == (O_SPD_MON > 16'h270f))
		else $error("Speed dash flag");
	net_hz_a: assert property (I_NET_OPT |=>
		O_OUT_UNIT == sdsc_pkg::SDSC_U_HZ &&
		O_SPD_UNIT == sdsc_pkg::SDSC_U_HZ) else $error("Network unit");
endmodule : sdsc_sva
bind sdsc_top sdsc_sva i_sdsc_sva (.I_CLK(I_CLK), .I_NRST(I_NRST),
	.I_WR_SCALE(I_WR_SCALE), .I_WR_MPOLE(I_WR_MPOLE), .I_WDATA(I_WDATA),
	.I_OUT_FREQ(I_OUT_FREQ), .I_CTRL_MODE(I_CTRL_MODE),
	.I_NET_OPT(I_NET_OPT), .O_SCALE(O_SCALE), .O_POLE(O_POLE),
	.O_REFF(O_REFF), .O_RES(O_RES), .O_WR_REJ(O_WR_REJ),
	.O_SPD_MON(O_SPD_MON), .O_OUT_UNIT(O_OUT_UNIT),
	.O_SPD_UNIT(O_SPD_UNIT), .O_DASH(O_DASH),
	.O_SPD_TENTH(O_SPD_TENTH), .O_TRQ_FINE(O_TRQ_FINE));

// >>> bench/speed_display_scaling_bench.sv
// Self-checking bench for the speed display scaling block
module speed_display_scaling_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, net = 1'b0, rej, rj, tnth, trq;
	logic [4:0] wr;
	logic [15:0] wd, maxf = 16'h2ee0, outf = 16'h0000, estf = 16'h0000;
	logic [15:0] setf = 16'h0000, encf = 16'h0000, spdc = 16'h0000;
	logic [15:0] om, sm, stm, cmd, lim;
	logic [13:0] scale;
	logic [7:0] pole;
	logic [6:0] reff;
	logic [3:0] res;
	logic [2:0] dash;
	sdsc_pkg::sdsc_ctrl_t mode = sdsc_pkg::SDSC_CM_VF;
	sdsc_pkg::sdsc_unit_t ou, su, stu, pu;
	int failures = 0, checks = 0, cyc = 0;
	always #2 clk = ~clk;
	sdsc_host i_sdsc_host (.i_clk(clk), .i_rej(rej), .o_wr(wr), .o_wdata(wd));
	sdsc_top i_sdsc_top (.I_CLK(clk), .I_NRST(nrst), .I_WR_SCALE(wr[0]),
		.I_WR_POLE(wr[1]), .I_WR_REFF(wr[2]), .I_WR_RES(wr[3]),
		.I_WR_MPOLE(wr[4]), .I_WDATA(wd), .I_MAX_FREQ(maxf),
		.I_OUT_FREQ(outf), .I_SET_FREQ(setf), .I_EST_FREQ(estf),
		.I_ENC_FREQ(encf), .I_CTRL_MODE(mode), .I_NET_OPT(net),
		.I_SPD_CMD(spdc), .O_SCALE(scale), .O_POLE(pole), .O_REFF(reff),
		.O_RES(res), .O_WR_REJ(rej), .O_OUT_MON(om), .O_SET_MON(stm),
		.O_SPD_MON(sm), .O_OUT_UNIT(ou), .O_SET_UNIT(stu), .O_SPD_UNIT(su),
		.O_PAR_UNIT(pu), .O_DASH(dash), .O_CMD_FREQ(cmd),
		.O_SPD_TENTH(tnth), .O_TRQ_FINE(trq), .O_SCALE_LIM(lim));
	task automatic results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	// Write one setting and compare the refusal pulse
	task automatic w(input int k, input logic [15:0] d, input logic e);
		i_sdsc_host.wr(k, d, rj);
		chk(16'(rj), 16'(e));
	endtask : w
	// Monitors lag a setting write by two edges
	task automatic wt;
		repeat (3) @(posedge clk);
		#1;
	endtask : wt
	// Hang guard, the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		wt();
		chk(16'(scale), 16'h0000);
		chk(16'(pole), 16'h0004);
		chk(16'(reff), 16'h003c);
		chk(16'(res), 16'h0000);
		chk(lim, 16'h270e);
		w(4, 16'h000c, 1'b0);
		chk(16'(pole), 16'h0002);
		w(1, 16'h0068, 1'b0);
		w(4, 16'h0002, 1'b0);
		chk(16'(pole), 16'h0066);
		w(1, 16'h0003, 1'b1);
		w(1, 16'h0070, 1'b1);
		chk(16'(pole), 16'h0066);
		w(1, 16'h0000, 1'b0);
		outf <= 16'h1770;
		estf <= 16'h0bb8;
		setf <= 16'h1388;
		encf <= 16'h05dc;
		spdc <= 16'h0fa0;
		wt();
		chk(sm, 16'h0708);
		chk(om, 16'h1770);
		chk(16'(ou), 16'(sdsc_pkg::SDSC_U_HZ));
		chk(16'(su), 16'(sdsc_pkg::SDSC_U_RPM));
		chk(stm, 16'h1388);
		chk(16'(stu), 16'(sdsc_pkg::SDSC_U_HZ));
		chk(16'(pu), 16'(sdsc_pkg::SDSC_U_HZ));
		chk(cmd, 16'h0fa0);
		mode <= sdsc_pkg::SDSC_CM_SENSORLESS;
		wt();
		chk(sm, 16'h0384);
		mode <= sdsc_pkg::SDSC_CM_ENCODER;
		wt();
		chk(sm, 16'h01c2);
		mode <= sdsc_pkg::SDSC_CM_VF;
		w(3, 16'h0001, 1'b0);
		wt();
		chk(sm, 16'h4650);
		chk(16'(tnth), 16'h0001);
		w(3, 16'h000a, 1'b0);
		chk(16'(trq), 16'h0001);
		w(3, 16'h0005, 1'b1);
		w(3, 16'h0000, 1'b0);
		w(2, 16'h0000, 1'b1);
		w(2, 16'h0079, 1'b1);
		w(2, 16'h0078, 1'b0);
		w(2, 16'h003c, 1'b0);
		w(0, 16'h270f, 1'b1);
		maxf <= 16'hffff;
		w(0, 16'h1770, 1'b1);
		w(0, 16'h176f, 1'b0);
		chk(lim, 16'h176f);
		w(0, 16'h03e8, 1'b0);
		outf <= 16'h0bb8;
		wt();
		chk(sm, 16'h01f4);
		chk(16'(su), 16'(sdsc_pkg::SDSC_U_MACH));
		chk(16'(ou), 16'(sdsc_pkg::SDSC_U_HZ));
		w(1, 16'h0004, 1'b0);
		wt();
		chk(om, 16'h01f4);
		chk(16'(ou), 16'(sdsc_pkg::SDSC_U_MACH));
		chk(stm, 16'h0341);
		chk(16'(pu), 16'(sdsc_pkg::SDSC_U_MACH));
		chk(cmd, 16'h5dc0);
		w(1, 16'h0068, 1'b0);
		wt();
		chk(sm, 16'h0384);
		chk(16'(ou), 16'(sdsc_pkg::SDSC_U_HZ));
		w(1, 16'h0000, 1'b0);
		w(0, 16'h176f, 1'b0);
		outf <= 16'h2ee0;
		wt();
		chk(16'(dash), 16'h0005);
		chk(sm, 16'h2ede);
		w(0, 16'h0000, 1'b0);
		w(1, 16'h006a, 1'b0);
		wt();
		chk(om, 16'h0960);
		chk(stm, 16'h03e8);
		chk(sm, 16'h0960);
		chk(cmd, 16'h4e20);
		chk(16'(pu), 16'(sdsc_pkg::SDSC_U_RPM));
		net <= 1'b1;
		wt();
		chk(16'(su), 16'(sdsc_pkg::SDSC_U_HZ));
		chk(16'(ou), 16'(sdsc_pkg::SDSC_U_HZ));
		chk(om, 16'h2ee0);
		results();
	end
endmodule : speed_display_scaling_bench

// >>> src/sdsc_pkg.sv
// Types shared by the speed display scaling block
package sdsc_pkg;
	// Display or setting increment of one quantity
	typedef enum logic [1:0] {
		SDSC_U_HZ,
		SDSC_U_RPM,
		SDSC_U_MACH
	} sdsc_unit_t;
	// Drive control mode, selects the speed source
	typedef enum logic [1:0] {
		SDSC_CM_VF,
		SDSC_CM_SENSORLESS,
		SDSC_CM_ENCODER
	} sdsc_ctrl_t;
endpackage : sdsc_pkg

// >>> src/sdsc_regs.svh
// Reset values, setting limits and conversion constants for speed scaling
`ifndef SDSC_REGS_SVH
`define SDSC_REGS_SVH
`define SDSC_SCALE_RST  14'h0000
`define SDSC_SCALE_CAP  16'h270e
`define SDSC_POLE_RST   8'h04
`define SDSC_POLE_OFS   8'h64
`define SDSC_POLE_DEF   4'h4
`define SDSC_REFF_RST   7'h3c
`define SDSC_REFF_MIN   16'h0001
`define SDSC_REFF_MAX   16'h0078
`define SDSC_RES_RST    4'h0
`define SDSC_RES_TENTH  0
`define SDSC_RES_FINE   3
`define SDSC_RPM_K      32'h00000078
`define SDSC_HZ_DIV     32'h00000064
`define SDSC_TENTH_DIV  32'h0000000a
`define SDSC_DASH_LIM   16'h270f
`define SDSC_BOUND_K    32'h0000ffff
`define SDSC_MPOLE_ALT  8'h0a
`endif

// >>> src/sdsc_top.sv
// Speed display scaling: settings, unit selection and monitor conversion
// Function
// (R1) Nonzero scale shows machine speed as scale times frequency over reference
// (R2) Pole setting accepts 0, 2..10 even, 102..110 even; resets to 4
// (R3) Motor pole write updates pole setting keeping offset; 12 maps to 2
// (R4) Resolution 1 or 11 gives 0.1 r/min, 0 or 10 gives 1 r/min
// (R5) Resolution 0,1 give 0.1% torque steps; 10,11 give 0.01%
// (R6) Scale limit below 65535 times reference over maximum, capped 9998
// (R7) Zero scale: frequency items in Hz or r/min by pole setting
// (R8) Nonzero scale: machine units by pole setting per the unit table
// (R9) Motor speed in r/min is frequency times 120 over pole count
// (R10) Effective poles: setting minus 100 above 100, four when zero
// (R11) Reference frequency held in hertz, 1..120, reset to 60
// (R12) Panel shows dashes for any monitor value above 9999
// (R13) V/F uses output frequency; vector modes use estimated or encoder
// (R14) Network option fitted forces frequency display everywhere
// (R15) Out-of-range setting writes are refused, old value kept
`include "sdsc_regs.svh"
module sdsc_top (
	input  wire logic                I_CLK,        // System clock
	input  wire logic                I_NRST,       // Async reset, low
	input  wire logic                I_WR_SCALE,   // Write machine scale
	input  wire logic                I_WR_POLE,    // Write pole setting
	input  wire logic                I_WR_REFF,    // Write reference freq
	input  wire logic                I_WR_RES,     // Write resolution
	input  wire logic                I_WR_MPOLE,   // Write motor poles
	input  wire logic [15:0]         I_WDATA,      // Setting write data
	input  wire logic [15:0]         I_MAX_FREQ,   // Max freq, 0.01 Hz
	input  wire logic [15:0]         I_OUT_FREQ,   // Output freq, 0.01 Hz
	input  wire logic [15:0]         I_SET_FREQ,   // Set freq, 0.01 Hz
	input  wire logic [15:0]         I_EST_FREQ,   // Estimated speed, 0.01 Hz
	input  wire logic [15:0]         I_ENC_FREQ,   // Encoder speed, 0.01 Hz
	input  wire sdsc_pkg::sdsc_ctrl_t I_CTRL_MODE, // Control mode
	input  wire logic                I_NET_OPT,    // Network card fitted
	input  wire logic [15:0]         I_SPD_CMD,    // Speed setting value
	output logic [13:0]              O_SCALE,      // Machine speed scale
	output logic [7:0]               O_POLE,       // Pole count setting
	output logic [6:0]               O_REFF,       // Reference freq, Hz
	output logic [3:0]               O_RES,        // Resolution select
	output logic                     O_WR_REJ,     // Write refused pulse
	output logic [15:0]              O_OUT_MON,    // Output freq monitor
	output logic [15:0]              O_SET_MON,    // Set freq monitor
	output logic [15:0]              O_SPD_MON,    // Running speed monitor
	output sdsc_pkg::sdsc_unit_t     O_OUT_UNIT,   // Output monitor unit
	output sdsc_pkg::sdsc_unit_t     O_SET_UNIT,   // Set monitor unit
	output sdsc_pkg::sdsc_unit_t     O_SPD_UNIT,   // Speed monitor unit
	output sdsc_pkg::sdsc_unit_t     O_PAR_UNIT,   // Freq parameter unit
	output logic [2:0]               O_DASH,       // Dash flags out/set/spd
	output logic [15:0]              O_CMD_FREQ,   // Speed cmd, 0.01 Hz
	output logic                     O_SPD_TENTH,  // 0.1 r/min steps
	output logic                     O_TRQ_FINE,   // 0.01 % torque steps
	output logic [15:0]              O_SCALE_LIM   // Largest scale allowed
);

	// Clip a wide result to the 16-bit monitor range
	// Clipping stops a large product wrapping into a small reading
	function automatic logic [15:0] sat16(input logic [31:0] v);
		sat16 = (v > 32'h0000ffff) ? 16'hffff : v[15:0];
	endfunction : sat16

	// Legal pole settings
	// Odd counts and values from 12 to 101 are never legal
	function automatic logic pole_ok(input logic [15:0] v);
		case (v)
			16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a,
			16'h0066, 16'h0068, 16'h006a, 16'h006c, 16'h006e:
				pole_ok = 1'b1;
			default:
				pole_ok = 1'b0;
		endcase
	endfunction : pole_ok

	// Frequency to motor speed, whole or tenth r/min
	// Tenth steps divide by ten less, so the result is ten times finer
	// The caller never passes a zero pole count
	function automatic logic [15:0] rpm_of(input logic [15:0] f,
			input logic [3:0] p, input logic tenth);
		logic [31:0] num;
		logic [31:0] den;
		num = {16'h0000, f} * `SDSC_RPM_K; // R9
		den = {28'h0000000, p} * `SDSC_HZ_DIV;
		if (tenth)
			den = {28'h0000000, p} * `SDSC_TENTH_DIV; // R4
		rpm_of = sat16(num / den);
	endfunction : rpm_of

	// Frequency to machine speed
	// Reference is at least 1 Hz, so the divisor is never zero
	function automatic logic [15:0] mach_of(input logic [15:0] f,
			input logic [13:0] s, input logic [6:0] r);
		logic [31:0] num;
		logic [31:0] den;
		num = {18'h00000, s} * {16'h0000, f}; // R1
		den = {25'h0000000, r} * `SDSC_HZ_DIV;
		mach_of = sat16(num / den);
	endfunction : mach_of

	// Setting registers and their next values
	logic [13:0] scale_r, scale_nxt;
	logic [7:0]  pole_r, pole_nxt;
	logic [6:0]  reff_r, reff_nxt;
	logic [3:0]  res_r, res_nxt;
	logic        rej_r, rej_nxt;

	// Scale bound from reference and maximum frequency
	// A zero maximum frequency is taken as no bound, leaving only the 9998 cap
	// Truncated quotient minus one stays strictly below the exact bound
	wire [31:0] bound_num = `SDSC_BOUND_K * {25'h0000000, reff_r}
		* `SDSC_HZ_DIV;
	wire [31:0] bound = (I_MAX_FREQ == 16'h0000) ? 32'hffffffff :
		bound_num / {16'h0000, I_MAX_FREQ};
	wire [31:0] lim_w = (bound > {16'h0000, `SDSC_SCALE_CAP}) ?
		{16'h0000, `SDSC_SCALE_CAP} : bound - 32'h00000001; // R6
	wire [15:0] scale_lim = (bound == 32'h00000000) ? 16'h0000 :
		lim_w[15:0];
	wire scale_ok = (I_WDATA == 16'h0000) ||
		(bound != 32'h00000000 && I_WDATA <= scale_lim); // R6

	// Legality of the other settings
	// Full 16-bit compares, so set upper bits cannot alias a legal value
	wire pole_w_ok = pole_ok(I_WDATA); // R2
	wire reff_ok = (I_WDATA >= `SDSC_REFF_MIN) &&
		(I_WDATA <= `SDSC_REFF_MAX); // R11
	wire res_ok = (I_WDATA == 16'h0000) || (I_WDATA == 16'h0001) ||
		(I_WDATA == 16'h000a) || (I_WDATA == 16'h000b);

	// Motor pole write: alternate codes 12..20 fold onto 2..10
	// Upper byte must be zero so a large word cannot fold onto 2..10
	// An offset pole setting keeps its plus-100 form after the write
	wire        mp_alt = (I_WDATA >= 16'h000c) && (I_WDATA <= 16'h0014);
	wire [7:0]  mp_fold = mp_alt ? I_WDATA[7:0] - `SDSC_MPOLE_ALT :
		I_WDATA[7:0]; // R3
	wire        mp_ok = (I_WDATA[15:8] == 8'h00) && (mp_fold != 8'h00) &&
		pole_ok({8'h00, mp_fold}) && (mp_fold < `SDSC_POLE_OFS);
	wire        pole_hi = pole_r > `SDSC_POLE_OFS;
	wire [7:0]  mp_pole = pole_hi ? mp_fold + `SDSC_POLE_OFS : mp_fold;

	// Next values of the settings; motor pole write beats a direct one
	// A refused write keeps the old value and raises the refusal pulse
	always_comb begin
		scale_nxt = scale_r;
		pole_nxt = pole_r;
		reff_nxt = reff_r;
		res_nxt = res_r;
		rej_nxt = 1'b0;
		if (I_WR_SCALE) begin
			if (scale_ok)
				scale_nxt = I_WDATA[13:0]; // R1
			else
				rej_nxt = 1'b1; // R15
		end
		if (I_WR_MPOLE) begin
			if (mp_ok)
				pole_nxt = mp_pole; // R3
			else
				rej_nxt = 1'b1; // R15
		end else if (I_WR_POLE) begin
			if (pole_w_ok)
				pole_nxt = I_WDATA[7:0]; // R2
			else
				rej_nxt = 1'b1; // R15
		end
		if (I_WR_REFF) begin
			if (reff_ok)
				reff_nxt = I_WDATA[6:0]; // R11
			else
				rej_nxt = 1'b1; // R15
		end
		if (I_WR_RES) begin
			if (res_ok)
				res_nxt = I_WDATA[3:0];
			else
				rej_nxt = 1'b1; // R15
		end
	end

	// Setting registers
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			scale_r <= `SDSC_SCALE_RST;
			pole_r <= `SDSC_POLE_RST; // R2
			reff_r <= `SDSC_REFF_RST; // R11
			res_r <= `SDSC_RES_RST;
			rej_r <= 1'b0;
		end else begin
			scale_r <= scale_nxt;
			pole_r <= pole_nxt;
			reff_r <= reff_nxt;
			res_r <= res_nxt;
			rej_r <= rej_nxt;
		end
	end

	// Effective pole count for r/min conversion
	// Only even settings get here, so the low nibble is the pole count
	wire [7:0] pole_low = pole_r - `SDSC_POLE_OFS;
	wire [3:0] eff_pole = pole_hi ? pole_low[3:0] :
		(pole_r == 8'h00) ? `SDSC_POLE_DEF : pole_r[3:0]; // R10

	// Resolution decode
	// Bit 0 picks tenth r/min steps, bit 3 the fine torque step
	wire tenth = res_r[`SDSC_RES_TENTH]; // R4
	wire fine = res_r[`SDSC_RES_FINE]; // R5

	// Unit selection; network card overrides everything
	// Zero scale: offset poles move every frequency item to r/min
	// Nonzero scale: plain poles move every item to machine units
	wire scale_zero = scale_r == 14'h0000;
	wire pole_mid = !pole_hi && (pole_r != 8'h00);
	sdsc_pkg::sdsc_unit_t u_freq, u_spd;
	assign u_freq = I_NET_OPT ? sdsc_pkg::SDSC_U_HZ : // R14
		scale_zero ? (pole_hi ? sdsc_pkg::SDSC_U_RPM : // R7
		sdsc_pkg::SDSC_U_HZ) :
		(pole_mid ? sdsc_pkg::SDSC_U_MACH : sdsc_pkg::SDSC_U_HZ); // R8
	assign u_spd = I_NET_OPT ? sdsc_pkg::SDSC_U_HZ : // R14
		scale_zero ? sdsc_pkg::SDSC_U_RPM : // R7
		(pole_hi ? sdsc_pkg::SDSC_U_RPM : sdsc_pkg::SDSC_U_MACH); // R8

	// Speed source depends on control mode: V/F shows synchronous speed
	// Mode code 3 is unused and falls back to the encoder speed
	wire [15:0] spd_src = (I_CTRL_MODE == sdsc_pkg::SDSC_CM_VF) ?
		I_OUT_FREQ :
		(I_CTRL_MODE == sdsc_pkg::SDSC_CM_SENSORLESS) ?
		I_EST_FREQ : I_ENC_FREQ; // R13

	// Monitor sources and units, index 0 out, 1 set, 2 speed
	wire [15:0] mon_f [3];
	sdsc_pkg::sdsc_unit_t mon_u [3];
	wire [15:0] mon_v [3];
	wire [2:0]  mon_dash;
	assign mon_f[0] = I_OUT_FREQ;
	assign mon_f[1] = I_SET_FREQ;
	assign mon_f[2] = spd_src;
	assign mon_u[0] = u_freq;
	assign mon_u[1] = u_freq;
	assign mon_u[2] = u_spd;

	// Each monitor converts the same way, only source and unit differ
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_mon
			assign mon_v[gi] =
				(mon_u[gi] == sdsc_pkg::SDSC_U_RPM) ?
				rpm_of(mon_f[gi], eff_pole, tenth) :
				(mon_u[gi] == sdsc_pkg::SDSC_U_MACH) ?
				mach_of(mon_f[gi], scale_r, reff_r) : mon_f[gi];
			// Four-digit panel cannot show more than 9999
			assign mon_dash[gi] = mon_v[gi] > `SDSC_DASH_LIM; // R12
		end
	endgenerate

	// Speed setting back to frequency in the parameter unit
	// Integer division rounds the command down by up to one step
	wire [31:0] cmd_rpm_num = {16'h0000, I_SPD_CMD} *
		{28'h0000000, eff_pole} * `SDSC_HZ_DIV;
	wire [31:0] cmd_rpm_den = tenth ?
		`SDSC_RPM_K * `SDSC_TENTH_DIV : `SDSC_RPM_K; // R4
	wire [31:0] cmd_mach_num = {16'h0000, I_SPD_CMD} *
		{25'h0000000, reff_r} * `SDSC_HZ_DIV;
	// A zero scale never selects machine units, divisor guarded anyway
	wire [31:0] cmd_mach_den = scale_zero ? 32'h00000001 :
		{18'h00000, scale_r};
	wire [15:0] cmd_freq =
		(u_freq == sdsc_pkg::SDSC_U_RPM) ?
		sat16(cmd_rpm_num / cmd_rpm_den) : // R9
		(u_freq == sdsc_pkg::SDSC_U_MACH) ?
		sat16(cmd_mach_num / cmd_mach_den) : I_SPD_CMD; // R1

	// Output registers; data outputs are flopped for clean timing
	// Units are flopped with the values so a reader sees them agree
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_OUT_MON <= 16'h0000;
			O_SET_MON <= 16'h0000;
			O_SPD_MON <= 16'h0000;
			O_DASH <= 3'h0;
			O_OUT_UNIT <= sdsc_pkg::SDSC_U_HZ;
			O_SET_UNIT <= sdsc_pkg::SDSC_U_HZ;
			O_SPD_UNIT <= sdsc_pkg::SDSC_U_RPM;
			O_PAR_UNIT <= sdsc_pkg::SDSC_U_HZ;
			O_CMD_FREQ <= 16'h0000;
		end else begin
			O_OUT_MON <= mon_v[0];
			O_SET_MON <= mon_v[1];
			O_SPD_MON <= mon_v[2];
			O_DASH <= mon_dash; // R12
			O_OUT_UNIT <= mon_u[0];
			O_SET_UNIT <= mon_u[1];
			O_SPD_UNIT <= mon_u[2];
			O_PAR_UNIT <= u_freq; // R7
			O_CMD_FREQ <= cmd_freq;
		end
	end

	// Settings and decoded flags straight from their registers; scale limit is combinational
	assign O_SCALE = scale_r;
	assign O_POLE = pole_r;
	assign O_REFF = reff_r;
	assign O_RES = res_r;
	assign O_WR_REJ = rej_r;
	assign O_SPD_TENTH = tenth; // R4
	assign O_TRQ_FINE = fine; // R5
	assign O_SCALE_LIM = scale_lim;

endmodule : sdsc_top
